// [logic/lrx_cfg.svh]
// Timing counts, frame layout and reset values of the link receiver.
`ifndef LRX_CFG_SVH
`define LRX_CFG_SVH

// -------------------------------------------------------------------------
// Core clock
// -------------------------------------------------------------------------
`define LRX_CLK_MHZ       250

// -------------------------------------------------------------------------
// Serial frame layout
// -------------------------------------------------------------------------
`define LRX_LANES         4
`define LRX_BITS          7
`define LRX_LAST_BIT      3'h6
`define LRX_LOCK_FRAMES   3'h4

// -------------------------------------------------------------------------
// Timing
// -------------------------------------------------------------------------
`define LRX_PDD_NS        1000
`define LRX_PDD_CYC       ((`LRX_PDD_NS * `LRX_CLK_MHZ) / 1000)
`define LRX_MIN_LINK_MHZ  20
`define LRX_LOSS_NS       1000
`define LRX_LOSS_CYC      ((`LRX_LOSS_NS * `LRX_CLK_MHZ) / 1000)
`define LRX_LOCK_MS       10

// -------------------------------------------------------------------------
// Reset values
// -------------------------------------------------------------------------
`define LRX_PIXEL_RST     28'h000_0000

`endif

// [logic/lrx_pkg.sv]
// Types shared by the link receiver modules.
package lrx_pkg;

   typedef struct packed {
      logic       spare_control;
      logic       pixel_valid;
      logic       frame_sync;
      logic       line_sync;
      logic [7:0] blue;
      logic [7:0] green;
      logic [7:0] red;
   } lrx_pixel_t;

   typedef struct packed {
      logic            aligned;
      logic [3:0][6:0] bits;
   } lrx_frame_t;

endpackage : lrx_pkg

// [logic/lrx_lane.sv]
// One serial lane: pin synchroniser and seven-bit shift register.
`timescale 1ns/100ps
module lrx_lane (
   // Link clock and reset
   input  wire logic       i_bit_clock,
   input  wire logic       i_rst,
   // Serial pin
   input  wire logic       i_lane_in,
   // Sampled bit and last seven bits, bit 0 oldest
   output logic            o_bit,
   output logic [6:0]      o_word
);

   logic sync1_r;

   always_ff @(posedge i_bit_clock) begin
      sync1_r <= i_lane_in;
      o_bit   <= sync1_r;
   end

   always_ff @(posedge i_bit_clock) begin
      if (i_rst) begin
         o_word <= 7'h00;
      end else begin
         o_word <= {o_bit, o_word[6:1]};
      end
   end

endmodule : lrx_lane

// [logic/lrx_top.sv]
// Serial display-link receiver: four lanes to a parallel pixel word.
`timescale 1ns/100ps
`include "lrx_cfg.svh"
module lrx_top (
   // Core clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_rst,
   // Link side
   input  wire logic              i_bit_clock,
   input  wire logic              i_link_clock_in,
   input  wire logic [3:0]        i_serial_lane_in,
   // Control pins
   input  wire logic              i_sleep_n,
   input  wire logic              i_wide_mode,
   // Parallel side
   output lrx_pkg::lrx_pixel_t    o_parallel_pixel_out,
   output logic                   o_pixel_strobe_out,
   output logic                   o_locked
);

   // ----------------------------------------------------------------------
   // Link domain: reset crossing and lane capture
   // ----------------------------------------------------------------------
   logic                lrst_s1_r;
   logic                lrst_r;
   logic [3:0]          lane_bit;
   logic [3:0][6:0]     lane_word;
   logic                ck_bit;
   logic                ck_prev_r;
   logic                ck_edge;
   logic [2:0]          cnt_r;
   logic [2:0]          idx;
   logic                in_frame_r;
   logic                cap_r;
   logic [2:0]          good_r;
   lrx_pkg::lrx_frame_t hold_r;
   logic                tog_r;

   always_ff @(posedge i_bit_clock) begin
      lrst_s1_r <= i_rst;
      lrst_r    <= lrst_s1_r;
   end

   genvar g;
   generate
      for (g = 0; g < `LRX_LANES; g = g + 1) begin : g_lane
         lrx_lane u_lane (
            .i_bit_clock (i_bit_clock),
            .i_rst       (lrst_r),
            .i_lane_in   (i_serial_lane_in[g]),
            .o_bit       (lane_bit[g]),
            .o_word      (lane_word[g])
         );
      end
   endgenerate

   lrx_lane u_clock_lane (
      .i_bit_clock (i_bit_clock),
      .i_rst       (lrst_r),
      .i_lane_in   (i_link_clock_in),
      .o_bit       (ck_bit),
      .o_word      ()
   );

   // ----------------------------------------------------------------------
   // Link domain: framing on the rising edge of the clock lane
   // ----------------------------------------------------------------------
   // A rising clock lane marks bit 0; a stuck lane gives no frames.
   assign ck_edge = ck_bit & ~ck_prev_r;
   assign idx     = ck_edge ? 3'h0 : cnt_r;

   always_ff @(posedge i_bit_clock) begin
      if (lrst_r) begin
         ck_prev_r  <= 1'b1;
         cnt_r      <= `LRX_LAST_BIT;
         in_frame_r <= 1'b0;
         cap_r      <= 1'b0;
      end else begin
         ck_prev_r  <= ck_bit;
         cnt_r      <= (idx == `LRX_LAST_BIT) ? `LRX_LAST_BIT : 3'(idx + 3'h1);
         in_frame_r <= ck_edge ? 1'b1 : ((idx == `LRX_LAST_BIT) ? 1'b0 : in_frame_r);
         cap_r      <= (idx == `LRX_LAST_BIT) && (in_frame_r || ck_edge);
      end
   end

   // An edge seven or eight bits after the last counts toward alignment.
   always_ff @(posedge i_bit_clock) begin
      if (lrst_r) begin
         good_r <= 3'h0;
      end else if (ck_edge) begin
         if (cnt_r == `LRX_LAST_BIT && !in_frame_r) begin
            good_r <= (good_r == `LRX_LOCK_FRAMES) ? good_r : 3'(good_r + 3'h1);
         end else begin
            good_r <= 3'h0;
         end
      end else if (cnt_r == `LRX_LAST_BIT && !in_frame_r && !cap_r) begin
         good_r <= 3'h0;
      end
   end

   // Completed frame is parked and announced by a toggle.
   always_ff @(posedge i_bit_clock) begin
      if (lrst_r) begin
         hold_r <= '0;
         tog_r  <= 1'b0;
      end else if (cap_r) begin
         hold_r.bits    <= lane_word;
         hold_r.aligned <= (good_r == `LRX_LOCK_FRAMES);
         tog_r          <= ~tog_r;
      end
   end

   // ----------------------------------------------------------------------
   // Core domain: pin and toggle synchronisers
   // ----------------------------------------------------------------------
   logic slp_s1_r;
   logic slp_s2_r;
   logic wide_s1_r;
   logic wide_s2_r;
   logic tog_s1_r;
   logic tog_s2_r;
   logic tog_s3_r;
   logic new_word;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         slp_s1_r  <= 1'b0;
         slp_s2_r  <= 1'b0;
         wide_s1_r <= 1'b0;
         wide_s2_r <= 1'b0;
         tog_s1_r  <= 1'b0;
         tog_s2_r  <= 1'b0;
         tog_s3_r  <= 1'b0;
      end else begin
         slp_s1_r  <= i_sleep_n;
         slp_s2_r  <= slp_s1_r;
         wide_s1_r <= i_wide_mode;
         wide_s2_r <= wide_s1_r;
         tog_s1_r  <= tog_r;
         tog_s2_r  <= tog_s1_r;
         tog_s3_r  <= tog_s2_r;
      end
   end

   assign new_word = tog_s2_r ^ tog_s3_r;

   // ----------------------------------------------------------------------
   // Core domain: lane-to-pixel mapping
   // ----------------------------------------------------------------------
   function automatic lrx_pkg::lrx_pixel_t map_pixel(input logic [3:0][6:0] b, input logic wide);
      lrx_pkg::lrx_pixel_t p;
      p.red           = {b[3][1:0], b[0][5:0]};
      p.green         = {b[3][3:2], b[1][4:0], b[0][6]};
      p.blue          = {b[3][5:4], b[2][3:0], b[1][6:5]};
      p.line_sync     = b[2][4];
      p.frame_sync    = b[2][5];
      p.pixel_valid   = b[2][6];
      p.spare_control = b[3][6];
      if (!wide) begin
         p.red[7:6]      = 2'h0;
         p.green[7:6]    = 2'h0;
         p.blue[7:6]     = 2'h0;
         p.spare_control = 1'b0;
      end
      return p;
   endfunction : map_pixel

   lrx_pkg::lrx_pixel_t pix_nxt;

   assign pix_nxt = map_pixel(hold_r.bits, wide_s2_r);

   // ----------------------------------------------------------------------
   // Core domain: clock-loss watchdog and lock
   // ----------------------------------------------------------------------
   localparam int LOSS_CYC = `LRX_LOSS_CYC;
   localparam int PDD_CYC  = `LRX_PDD_CYC;

   logic [8:0] watch_r;
   logic       lost;

   // The timeout exceeds one frame at the slowest link clock.
   assign lost = (watch_r == 9'(LOSS_CYC));

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         watch_r <= 9'(LOSS_CYC);
      end else if (new_word) begin
         watch_r <= 9'h000;
      end else if (!lost) begin
         watch_r <= 9'(watch_r + 9'h001);
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst || !slp_s2_r || lost) begin
         o_locked <= 1'b0;
      end else if (new_word) begin
         o_locked <= hold_r.aligned;
      end
   end

   // ----------------------------------------------------------------------
   // Core domain: parallel outputs and regenerated strobe
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_parallel_pixel_out <= `LRX_PIXEL_RST;
      end else if (!slp_s2_r) begin
         o_parallel_pixel_out <= `LRX_PIXEL_RST;
      end else if (new_word && hold_r.aligned) begin
         o_parallel_pixel_out <= pix_nxt;
      end
   end

   // One-cycle strobe: data set up as it rises, valid at its fall.
   always_ff @(posedge i_clock) begin
      if (i_rst || !slp_s2_r || lost) begin
         o_pixel_strobe_out <= 1'b0;
      end else begin
         o_pixel_strobe_out <= new_word && hold_r.aligned;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence seq_sleep_enter;
      !slp_s2_r;
   endsequence

   sequence seq_outputs_low;
      (o_parallel_pixel_out == '0) && !o_pixel_strobe_out && !o_locked;
   endsequence

   AST_SLEEP_FORCE_LOW: assert property (@(posedge i_clock) disable iff (i_rst)
      seq_sleep_enter |=> seq_outputs_low)
      else $error("outputs not low while asleep");

   AST_SLEEP_DELAY: assert property (@(posedge i_clock) disable iff (i_rst)
      $fell(i_sleep_n) |-> ##[1:PDD_CYC] seq_outputs_low)
      else $error("sleep not reached in time");

   AST_STROBE_PULSE: assert property (@(posedge i_clock) disable iff (i_rst)
      o_pixel_strobe_out |=> !o_pixel_strobe_out && $stable(o_parallel_pixel_out))
      else $error("strobe wider than one cycle or data moved at fall");

   AST_DATA_WITH_STROBE: assert property (@(posedge i_clock) disable iff (i_rst)
      $changed(o_parallel_pixel_out) |-> o_pixel_strobe_out || !slp_s2_r)
      else $error("parallel data changed without a strobe");

   AST_STROBE_NEEDS_LOCK: assert property (@(posedge i_clock) disable iff (i_rst)
      (new_word && slp_s2_r && !lost && hold_r.aligned) |=> o_pixel_strobe_out && o_locked)
      else $error("aligned word did not strobe");

   AST_LOST_STROBE_LOW: assert property (@(posedge i_clock) disable iff (i_rst)
      lost |=> !o_pixel_strobe_out && !o_locked)
      else $error("strobe active with clock lost");

   AST_WIDE_MAP: assert property (@(posedge i_clock) disable iff (i_rst)
      (new_word && slp_s2_r && hold_r.aligned && wide_s2_r) |=>
         o_parallel_pixel_out.red == {$past(hold_r.bits[3][1:0]), $past(hold_r.bits[0][5:0])})
      else $error("wide red mapping wrong");

   AST_NARROW_ZERO: assert property (@(posedge i_clock) disable iff (i_rst)
      (new_word && hold_r.aligned && !wide_s2_r) |=>
         o_parallel_pixel_out.red[7:6] == 2'h0 && !o_parallel_pixel_out.spare_control)
      else $error("narrow mode drives unused bits");

   AST_FRAME_CAPTURE: assert property (@(posedge i_bit_clock) disable iff (lrst_r)
      cap_r |=> $changed(tog_r) && hold_r.bits == $past(lane_word))
      else $error("frame not parked after seventh bit");

   AST_NO_CLOCK_NO_FRAME: assert property (@(posedge i_bit_clock) disable iff (lrst_r)
      (!ck_edge && !in_frame_r) |=> !cap_r)
      else $error("frame captured without clock edge");

endmodule : lrx_top

// [test/lrx_tx_model.sv]
// Behavioural serializing transmitter that drives the receiver's link lanes.
`timescale 1ns/100ps
module lrx_tx_model (
   // Link bit clock
   input  wire logic       i_bit_clock,
   // Serial lanes toward the receiver
   output logic            o_link_clock_in,
   output logic [3:0]      o_serial_lane_in
);
   // Undriven lanes sit high, as the failsafe bias would pull them.
   initial begin
      o_link_clock_in  = 1'b1;
      o_serial_lane_in = 4'hf;
   end

   // Sends one word as seven bits per lane, changing pins just after each edge.
   task automatic send(input logic [27:0] w);
      lrx_pkg::lrx_pixel_t p;
      lrx_pkg::lrx_frame_t f;
      p         = w;
      f.aligned = 1'b1;
      f.bits[0] = {p.green[0], p.red[5:0]};
      f.bits[1] = {p.blue[1:0], p.green[5:1]};
      f.bits[2] = {p.pixel_valid, p.frame_sync, p.line_sync, p.blue[5:2]};
      f.bits[3] = {p.spare_control, p.blue[7:6], p.green[7:6], p.red[7:6]};
      for (int b = 0; b < 7; b++) begin
         @(posedge i_bit_clock);
         #1;
         o_link_clock_in = (b < 4) ? 1'b1 : 1'b0;
         for (int l = 0; l < 4; l++) begin
            o_serial_lane_in[l] = f.bits[l][b];
         end
      end
   endtask : send

   // Releases all lanes; they float high.
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge i_bit_clock);
         #1;
         o_link_clock_in  = 1'b1;
         o_serial_lane_in = 4'hf;
      end
   endtask : idle
endmodule : lrx_tx_model

// [test/lrx_top_tb_top.sv]
// Self-checking bench for the link receiver with a queue-based word model.
`timescale 1ns/100ps
`define CHK(name, exp, got) begin n_checks++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR %s expected %h seen %h", name, exp, got); end end
module lrx_top_tb_top;
   localparam logic [27:0] PRE = 28'h5a3_c96e;
   logic                   i_clock     = 1'b0;
   logic                   i_rst       = 1'b1;
   logic                   i_bit_clock = 1'b0;
   logic                   i_sleep_n   = 1'b1;
   logic                   i_wide_mode = 1'b1;
   wire logic              link_clock;
   wire logic [3:0]        lanes;
   lrx_pkg::lrx_pixel_t    pixel_out;
   logic                   strobe;
   logic                   locked;
   int                     fails       = 0;
   int                     n_checks    = 0;
   int                     cyc         = 0;
   logic                   asleep      = 1'b0;
   logic                   lost        = 1'b0;
   logic                   saw_rnd     = 1'b0;
   logic [31:0]            lfsr        = 32'h0000_0053;
   lrx_pkg::lrx_pixel_t    q[$];
   lrx_pkg::lrx_pixel_t    last_exp;
   lrx_pkg::lrx_pixel_t    exp_w;

   always #2 i_clock = ~i_clock;
   initial begin
      #1.3;
      forever #24 i_bit_clock = ~i_bit_clock;
   end

   lrx_top u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_bit_clock(i_bit_clock), .i_link_clock_in(link_clock),
      .i_serial_lane_in(lanes), .i_sleep_n(i_sleep_n), .i_wide_mode(i_wide_mode),
      .o_parallel_pixel_out(pixel_out), .o_pixel_strobe_out(strobe), .o_locked(locked));
   lrx_tx_model u_tx (.i_bit_clock(i_bit_clock), .o_link_clock_in(link_clock), .o_serial_lane_in(lanes));

   // ----------------------------------------------------------------------
   // Word model and scoreboard
   // ----------------------------------------------------------------------
   function automatic lrx_pkg::lrx_pixel_t mask(input logic [27:0] w, input logic wide);
      lrx_pkg::lrx_pixel_t p;
      p = w;
      if (!wide) begin
         p.red[7:6]      = 2'b00;
         p.green[7:6]    = 2'b00;
         p.blue[7:6]     = 2'b00;
         p.spare_control = 1'b0;
      end
      return p;
   endfunction : mask

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // Strobe is a one-cycle pulse; sample it mid-cycle once settled.
   always @(negedge i_clock) begin
      if (!i_rst && strobe === 1'b1) begin
         if (asleep || lost) begin
            `CHK("strobe", 1'b0, strobe)
         end else if (!saw_rnd && pixel_out === mask(PRE, i_wide_mode)) begin
            `CHK("preamble lock", 1'b1, locked)
            last_exp = pixel_out;
         end else if (q.size() > 0) begin
            saw_rnd = 1'b1;
            exp_w = q.pop_front();
            `CHK("pixel", exp_w, pixel_out)
            last_exp = exp_w;
         end else begin
            `CHK("extra strobe", 1'b0, strobe)
         end
      end
   end

   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         conclude();
      end
   end

   task automatic conclude();
      if (fails == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Preamble lets the receiver align, then random and all-ones words follow.
   task automatic run(input int n);
      logic [27:0] w;
      q.delete();
      saw_rnd = 1'b0;
      repeat (8) u_tx.send(PRE);
      for (int k = 0; k < n; k++) begin
         lfsr = lfsr_next(lfsr);
         w = (k % 4 == 3) ? 28'hfff_ffff : lfsr[27:0];
         q.push_back(mask(w, i_wide_mode));
         u_tx.send(w);
      end
      // The released clock lane rises once more and frames an all-ones word.
      q.push_back(mask(28'hfff_ffff, i_wide_mode));
      u_tx.idle(3);
      for (int i = 0; i < 200 && q.size() > 0; i++) @(negedge i_clock);
      `CHK("words pending", 0, q.size())
      `CHK("locked", 1'b1, locked)
   endtask : run

   // Clock lane floats: strobe stays low and data keeps its last value.
   task automatic lose_clock();
      lost = 1'b1;
      u_tx.idle(40);
      `CHK("held pixel", last_exp, pixel_out)
      `CHK("lock lost", 1'b0, locked)
      lost = 1'b0;
   endtask : lose_clock

   initial begin
      repeat (40) @(negedge i_clock);
      i_rst = 1'b0;
      u_tx.idle(4);
      run(16);
      lose_clock();
      @(negedge i_clock);
      i_wide_mode = 1'b0;
      run(16);
      lose_clock();
      @(negedge i_clock);
      i_wide_mode = 1'b1;
      run(4);
      @(negedge i_clock);
      i_sleep_n = 1'b0;
      asleep = 1'b1;
      repeat (3) @(posedge i_clock);
      @(negedge i_clock);
      `CHK("sleep pixel", 28'h000_0000, pixel_out)
      `CHK("sleep strobe", 1'b0, strobe)
      repeat (3) u_tx.send(PRE);
      @(negedge i_clock);
      i_sleep_n = 1'b1;
      asleep = 1'b0;
      run(12);
      conclude();
   end
endmodule : lrx_top_tb_top
